/* core/ec_misc_control_registers.sv */
// Miscellaneous embedded-controller register bank: comparators, debug, tally, reference
// Contract
// - Bit5 selects comparator1 threshold: pin or dac
// - Bit4 enables comparator1, never locked
// - Bit2 lock makes bits 2:0 read-only
// - Bit1 selects comparator0 threshold: pin or dac
// - Bit0 enables comparator0, subject to lock
// - Boot-ready bit RW, mirrored to debugger status
// - Debug enable low ignores reset-pin, pins normal
// - Debug enable high: high reset-pin activates port
// - Tally RW, cleared only by standby reset
// - Bit1 disables cpu reference voltage when set
// - Subsystem reset restores subsystem-reset fields
// - Standby fields reset only on power-on
// - Register access still works while asleep
// Notes for users of this bank:
// Writes take effect on the edge that samples regWrite.
// Field outputs trail the stored bits by one more edge.
// Read data is registered, one edge after regRead.
// A read in the same cycle as a write returns the old value.
// Back-to-back accesses are fine, no wait states exist.
// The tally sits on the standby reset so it outlives
// watchdog-forced resets of the rest of the bank.
// Limitation: no byte strobes, every write is a full word.
// Limitation: the trst pin is taken as already synchronous.
`default_nettype none
module ec_misc_control_registers
  import ec_misc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic standbyPorRst,
  input wire logic sleepReq,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regWdata,
  input wire logic debugTrstPin,
  input wire logic [7:0] debugCmd,
  output logic [31:0] regRdata,
  output logic cmp0Enable,
  output logic cmp0UseDac,
  output logic cmp1Enable,
  output logic cmp1UseDac,
  output logic jtagActive,
  output logic bootReadyStatus,
  output logic vrefCpuDisable
);
  // Comparator storage
  logic cmp0Lock_r; // One-way lock for comparator 0
  logic cmp0En; // Comparator 0 enable bit
  logic cmp0Sel; // Comparator 0 threshold source
  logic cmp1En_r; // Comparator 1 enable bit
  logic cmp1Sel_r; // Comparator 1 threshold source
  // Debug enable and boot flag
  logic jtagEn_r; // Debug port permission
  logic bootRdy_r; // Boot configuration finished
  // Standby-domain tally
  logic [TALLY_W-1:0] watchdog_fire_tally_r; // Watchdog expiry count
  // Reference control
  logic vrefDis_r; // Reference voltage off
  logic [VREF_TEST_W-1:0] vrefTest_r; // Test bits, plain storage
  // Read mux result
  logic [31:0] rdata_nxt; // Word presented to the read flop

  // Address decode; sleep does not gate access
  // The full byte offset is compared, so aliases never hit
  // and writes to unmapped offsets are dropped
  wire hitCmp = regWrite && (regAddr == OFS_CMP_CTRL);
  wire hitDbg = regWrite && (regAddr == OFS_DBG_EN);
  wire hitTally = regWrite && (regAddr == OFS_WDT_TALLY);
  wire hitVref = regWrite && (regAddr == OFS_VREF_DIS);
  // Comparator 0 fields writable only while unlocked
  wire cmp0WrEn = hitCmp && !cmp0Lock_r;

  // Lock-gated comparator 0 enable and source select
  ec_rw_bit #(
    .RST_VAL(CMP_CTRL_RST[CMP0_EN_BIT])
  ) u_cmp0En (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(cmp0WrEn),
    .wrData(regWdata[CMP0_EN_BIT]),
    .q(cmp0En)
  );
  ec_rw_bit #(
    .RST_VAL(CMP_CTRL_RST[CMP0_SEL_BIT])
  ) u_cmp0Sel (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(cmp0WrEn),
    .wrData(regWdata[CMP0_SEL_BIT]),
    .q(cmp0Sel)
  );

  // Lock is set-only; zero writes cannot undo it
  // Only rst removes it, so firmware cannot reopen the fields
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmp0Lock_r <= 1'b0;
    end else if (hitCmp && regWdata[CMP0_LOCK_BIT]) begin
      cmp0Lock_r <= 1'b1;
    end
  end

  // Comparator 1 fields, never covered by the lock
  // Loaded on every write to the offset, lock or not
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmp1En_r <= CMP_CTRL_RST[CMP1_EN_BIT];
      cmp1Sel_r <= CMP_CTRL_RST[CMP1_SEL_BIT];
    end else if (hitCmp) begin
      cmp1En_r <= regWdata[CMP1_EN_BIT];
      cmp1Sel_r <= regWdata[CMP1_SEL_BIT];
    end
  end

  // Debug enable and boot-ready flag, subsystem reset
  // Firmware raises the ready flag once its setup is done
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      jtagEn_r <= 1'b0;
      bootRdy_r <= 1'b0;
    end else if (hitDbg) begin
      jtagEn_r <= regWdata[JTAG_EN_BIT];
      bootRdy_r <= regWdata[BOOT_RDY_BIT];
    end
  end

  // Tally lives on standby reset only; survives watchdog resets
  // rst is deliberately absent here, the count must outlive it
  always_ff @(posedge sys_clk or posedge standbyPorRst) begin
    if (standbyPorRst) begin
      watchdog_fire_tally_r <= TALLY_RST;
    end else if (hitTally) begin
      watchdog_fire_tally_r <= regWdata[TALLY_W-1:0];
    end
  end

  // Reference disable and its test field
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vrefDis_r <= 1'b0;
      vrefTest_r <= VREF_TEST_RST;
    end else if (hitVref) begin
      vrefDis_r <= regWdata[VREF_DIS_BIT];
      vrefTest_r <= regWdata[VREF_TEST_LO +: VREF_TEST_W];
    end
  end

  // Read mux; reserved bits assemble as zero
  // Unmapped offsets fall to the default arm
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (regAddr)
      OFS_CMP_CTRL: begin
        rdata_nxt[CMP0_EN_BIT] = cmp0En;
        rdata_nxt[CMP0_SEL_BIT] = cmp0Sel;
        rdata_nxt[CMP0_LOCK_BIT] = cmp0Lock_r;
        rdata_nxt[CMP1_EN_BIT] = cmp1En_r;
        rdata_nxt[CMP1_SEL_BIT] = cmp1Sel_r;
      end
      OFS_DBG_EN: begin
        rdata_nxt[JTAG_EN_BIT] = jtagEn_r;
        rdata_nxt[BOOT_RDY_BIT] = bootRdy_r;
      end
      OFS_WDT_TALLY: begin
        rdata_nxt[TALLY_W-1:0] = watchdog_fire_tally_r;
      end
      OFS_VREF_DIS: begin
        rdata_nxt[VREF_DIS_BIT] = vrefDis_r;
        rdata_nxt[VREF_TEST_LO +: VREF_TEST_W] = vrefTest_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000; // Unmapped reads return zero
      end
    endcase
  end

  // Registered read data; held when no read, one cycle latency
  // Holding the last word keeps the bus quiet between reads
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h0000_0000;
    end else if (regRead) begin
      regRdata <= rdata_nxt;
    end
  end

  // Gating of the debug port by enable and reset pin
  // Pin is taken as synchronous; no synchroniser here
  wire jtagActive_nxt = jtagEn_r && debugTrstPin;
  // Status mirror only answers the status command
  wire bootStatus_nxt = (debugCmd == DBG_STATUS_CMD) && bootRdy_r;

  // Outputs come straight from flops, one cycle behind state
  // Costs an edge of latency but keeps analog controls glitch-free
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmp0Enable <= 1'b0;
      cmp0UseDac <= 1'b0;
      cmp1Enable <= 1'b0;
      cmp1UseDac <= 1'b0;
      jtagActive <= 1'b0;
      bootReadyStatus <= 1'b0;
      vrefCpuDisable <= 1'b0;
    end else begin
      cmp0Enable <= cmp0En;
      cmp0UseDac <= cmp0Sel;
      cmp1Enable <= cmp1En_r;
      cmp1UseDac <= cmp1Sel_r;
      jtagActive <= jtagActive_nxt;
      bootReadyStatus <= bootStatus_nxt;
      vrefCpuDisable <= vrefDis_r;
    end
  end

  // Sleep request is accepted but does not block access
  // Kept as a named net so the port is visibly consumed
  wire sleepUnused = sleepReq;
endmodule
`default_nettype wire

/* include/ec_misc_pkg.sv */
// Package with offsets, field positions and reset values of the misc register bank
`default_nettype none
package ec_misc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMP_CTRL = 8'h18;
  localparam logic [7:0] OFS_DBG_EN = 8'h20;
  localparam logic [7:0] OFS_WDT_TALLY = 8'h28;
  localparam logic [7:0] OFS_VREF_DIS = 8'h40;
  // Comparator control fields
  localparam int CMP0_EN_BIT = 0;
  localparam int CMP0_SEL_BIT = 1;
  localparam int CMP0_LOCK_BIT = 2;
  localparam int CMP1_EN_BIT = 4;
  localparam int CMP1_SEL_BIT = 5;
  // Debug-enable fields
  localparam int JTAG_EN_BIT = 0;
  localparam int BOOT_RDY_BIT = 1;
  // Reference-disable fields
  localparam int VREF_DIS_BIT = 1;
  localparam int VREF_TEST_LO = 2;
  localparam int VREF_TEST_W = 5;
  // Tally width and status command
  localparam int TALLY_W = 4;
  localparam logic [7:0] DBG_STATUS_CMD = 8'h07;
  // Reset values
  localparam logic [5:0] CMP_CTRL_RST = 6'h00;
  localparam logic [3:0] TALLY_RST = 4'h0;
  localparam logic [4:0] VREF_TEST_RST = 5'h00;
endpackage
`default_nettype wire

/* core/ec_rw_bit.sv */
// Single writable control bit with lock-gated write enable
`default_nettype none
module ec_rw_bit #(
  parameter logic RST_VAL = 1'b0 // Value the bit takes on reset
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic wrData,
  output logic q
);
  // Bit returns to its reset value, loads on write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= RST_VAL;
    end else if (wrEn) begin
      q <= wrData;
    end
  end
endmodule
`default_nettype wire

/* verif/ec_misc_assertions.sv */
// Port timing checker for the misc register bank
`default_nettype none
module ec_misc_checker
  import ec_misc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic standbyPorRst,
  input wire logic sleepReq,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regWdata,
  input wire logic debugTrstPin,
  input wire logic [7:0] debugCmd,
  input wire logic [31:0] regRdata,
  input wire logic cmp0Enable,
  input wire logic cmp0UseDac,
  input wire logic cmp1Enable,
  input wire logic cmp1UseDac,
  input wire logic jtagActive,
  input wire logic bootReadyStatus,
  input wire logic vrefCpuDisable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Write strobes per register
  wire logic cmpHit = regWrite && regAddr == OFS_CMP_CTRL;
  wire logic vrefHit = regWrite && regAddr == OFS_VREF_DIS;
  // Comparator write, outputs settle two edges later
  sequence cmpWr;
    cmpHit ##2 1;
  endsequence
  AST_CMP1_EN: assert property (cmpWr |-> cmp1Enable == $past(regWdata[CMP1_EN_BIT], 2))
    else $error("cmp1 enable not taken");
  AST_CMP1_SEL: assert property ($changed(cmp1UseDac) |-> $past(cmpHit, 2))
    else $error("cmp1 select moved alone");
  AST_CMP0_EN: assert property ($changed(cmp0Enable) |-> $past(cmpHit, 2))
    else $error("cmp0 enable moved alone");
  AST_CMP0_SEL: assert property ($changed(cmp0UseDac) |-> $past(cmpHit, 2))
    else $error("cmp0 select moved alone");
  AST_VREF: assert property ($changed(vrefCpuDisable) |-> $past(vrefHit, 2))
    else $error("vref disable moved alone");
  AST_BOOT: assert property (bootReadyStatus |-> $past(debugCmd) == DBG_STATUS_CMD)
    else $error("boot status on wrong command");
  AST_JTAG: assert property (!$past(debugTrstPin) |-> !jtagActive)
    else $error("debug port active without pin");
  AST_RDATA: assert property ($changed(regRdata) |-> $past(regRead))
    else $error("read data moved without read");
endmodule
`default_nettype wire

/* verif/ec_misc_control_registers_bench.sv */
// Self-checking bench for the misc register bank
`default_nettype none
module ec_misc_control_registers_bench import ec_misc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst = 1, standbyPorRst = 1, sleepReq = 0;
  logic regWrite = 0, regRead = 0, debugTrstPin = 0;
  logic [7:0] regAddr = 8'h00, debugCmd = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic cmp0Enable, cmp0UseDac, cmp1Enable, cmp1UseDac;
  logic jtagActive, bootReadyStatus, vrefCpuDisable;
  int num_errors = 0, num_checks = 0, cycles = 0;
  // Offsets read at reset, one unmapped
  logic [7:0] ofs[5] = '{OFS_CMP_CTRL, OFS_DBG_EN, OFS_WDT_TALLY, OFS_VREF_DIS, 8'h24};
  always #12.5 sys_clk = ~sys_clk;
  ec_misc_control_registers dut_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .standbyPorRst(standbyPorRst),
    .sleepReq(sleepReq),
    .regAddr(regAddr),
    .regWrite(regWrite),
    .regRead(regRead),
    .regWdata(regWdata),
    .debugTrstPin(debugTrstPin),
    .debugCmd(debugCmd),
    .regRdata(regRdata),
    .cmp0Enable(cmp0Enable),
    .cmp0UseDac(cmp0UseDac),
    .cmp1Enable(cmp1Enable),
    .cmp1UseDac(cmp1UseDac),
    .jtagActive(jtagActive),
    .bootReadyStatus(bootReadyStatus),
    .vrefCpuDisable(vrefCpuDisable)
  );
  task automatic chk(logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Bus tasks start and end at a falling edge; idle edge after a write
  task automatic wr(logic [7:0] a, logic [31:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1;
    @(negedge sys_clk) regWrite = 0;
    @(negedge sys_clk);
  endtask
  // Data lands on the taking edge; checked two falling edges after the start
  task automatic rd(logic [7:0] a, logic [31:0] e);
    regAddr = a;
    regRead = 1;
    @(negedge sys_clk) regRead = 0;
    @(negedge sys_clk) chk(regRdata, e);
  endtask
  task automatic step(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, run needs well under this
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 3000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    step(4);
    rst = 0;
    standbyPorRst = 0;
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    $display("test defaults done");
    wr(OFS_CMP_CTRL, 32'hFFFF_FFFB);
    step(2);
    chk(32'({cmp1UseDac, cmp1Enable, cmp0UseDac, cmp0Enable}), 32'hF);
    rd(OFS_CMP_CTRL, 32'h33);
    rd(8'h24, 32'h0);
    // Lock with cmp0 cleared, then a write blocked for cmp0 only
    wr(OFS_CMP_CTRL, 32'h04);
    wr(OFS_CMP_CTRL, 32'h33);
    rd(OFS_CMP_CTRL, 32'h34);
    chk(32'({cmp1UseDac, cmp1Enable, cmp0UseDac, cmp0Enable}), 32'hC);
    $display("test comparator done");
    debugTrstPin = 1;
    debugCmd = DBG_STATUS_CMD;
    wr(OFS_DBG_EN, 32'hFFFF_FFFF);
    rd(OFS_DBG_EN, 32'h3);
    chk(32'({bootReadyStatus, jtagActive}), 32'h3);
    debugCmd = 8'h06;
    wr(OFS_DBG_EN, 32'h2);
    step(2);
    chk(32'({bootReadyStatus, jtagActive}), 32'h0);
    $display("test debug done");
    // Asleep, access must still work
    sleepReq = 1;
    wr(OFS_WDT_TALLY, 32'hFFFF_FFF9);
    wr(OFS_VREF_DIS, 32'hFFFF_FFFF);
    rd(OFS_WDT_TALLY, 32'h9);
    rd(OFS_VREF_DIS, 32'h7E);
    chk(32'(vrefCpuDisable), 32'h1);
    rst = 1;
    step(1);
    rst = 0;
    rd(OFS_WDT_TALLY, 32'h9);
    rd(OFS_CMP_CTRL, 32'h0);
    rd(OFS_VREF_DIS, 32'h0);
    chk(32'({vrefCpuDisable, bootReadyStatus, jtagActive, cmp1UseDac}), 32'h0);
    chk(32'({cmp1Enable, cmp0UseDac, cmp0Enable}), 32'h0);
    wr(OFS_CMP_CTRL, 32'h30);
    standbyPorRst = 1;
    step(1);
    standbyPorRst = 0;
    rd(OFS_WDT_TALLY, 32'h0);
    rd(OFS_CMP_CTRL, 32'h30);
    $display("test resets done");
    final_report();
  end
endmodule
bind ec_misc_control_registers ec_misc_checker chk_u (
  .sys_clk(sys_clk),
  .rst(rst),
  .standbyPorRst(standbyPorRst),
  .sleepReq(sleepReq),
  .regAddr(regAddr),
  .regWrite(regWrite),
  .regRead(regRead),
  .regWdata(regWdata),
  .debugTrstPin(debugTrstPin),
  .debugCmd(debugCmd),
  .regRdata(regRdata),
  .cmp0Enable(cmp0Enable),
  .cmp0UseDac(cmp0UseDac),
  .cmp1Enable(cmp1Enable),
  .cmp1UseDac(cmp1UseDac),
  .jtagActive(jtagActive),
  .bootReadyStatus(bootReadyStatus),
  .vrefCpuDisable(vrefCpuDisable)
);
`default_nettype wire
